// ### rtl/tid_core.sv
// Transfer-group instruction fetch, decode and execute for the 8-bit core
`timescale 1ns/100ps
`default_nettype none
`include "tid_map.svh"
// How it works
// - All 48 transfer instructions are decoded; other groups flag illegal
// - Accumulator is 8 or 16 bits; acc_high upper, acc_low lower byte
// - Temporary accumulator likewise splits into temp_high and temp_low
// - Index, extra, program counter, stack and status words are 16 bits
// - Condition flags are 8 bits; bank pointer is 5 bits
// - Each bank holds eight 8-bit general registers, indexed 0 to 7
// - Direct address operand is one byte; extended address is 16 bits
// - Bit-direct operand is 8-bit address plus 3-bit index
// - Byte load into accumulator copies old acc_low to temp_low only
// - Word store direct writes acc_high at address, acc_low next
// - Word load direct fills acc_high from address, acc_low from next
// - Word store extended writes acc_high then acc_low at plus one
// - Word load extended fills acc_high then acc_low from plus one
// - Indexed word store uses index plus offset, then plus one
// - Word store through extra pointer: high at pointer, low next
// - Word load through extra pointer: high at pointer, low next
// - Accumulator-indirect word load addresses memory by accumulator
// - Temp word store through accumulator: temp_high then temp_low
// - Register forms use eight consecutive opcodes; low bits pick register
// - Word results put their upper byte into acc_high

module tid_core
    import tid_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    output logic [15:0]      pmem_addr_o,
    output logic             pmem_rd_o,
    input  wire logic [7:0]  pmem_data_i,
    output logic [15:0]      dmem_addr_o,
    output logic [7:0]       dmem_wdata_o,
    output logic             dmem_we_o,
    output logic             dmem_re_o,
    input  wire logic [7:0]  dmem_rdata_i,
    output logic             instr_done_o,
    output logic             illegal_op_o,
    output logic [15:0]      acc_o,
    output logic [15:0]      temp_o,
    output logic [15:0]      index_pointer_o,
    output logic [15:0]      extra_pointer_o,
    output logic [15:0]      stack_ptr_o,
    output logic [15:0]      program_status_word_o
);

    tid_regs_s   r;
    tid_regs_s   next_r;
    logic [7:0]  op;
    logic [4:0]  grp;
    logic        bitop;
    logic        ri;
    logic        rd_b;
    logic        rd_w;
    logic        wr_b;
    logic        wr_w;
    logic [1:0]  len;
    logic [15:0] ea;
    logic [7:0]  bdat;
    logic [7:0]  mask;

    function automatic logic [7:0] with_nz(input logic [7:0] f,
                                           input logic       n,
                                           input logic       z);
        logic [7:0] v;
        v          = f;
        v[`CCR_N]  = n;
        v[`CCR_Z]  = z;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode
    always_comb begin
        next_r         = r;
        next_r.done    = 1'b0;
        next_r.illegal = 1'b0;
        // Opcode is still on the program bus during fetch
        op    = (r.state == S_FETCH) ? pmem_data_i : r.op;
        grp   = op[7:3];
        ri    = grp inside {`GRP_LD_RI, `GRP_ST_RI, `GRP_MI_RI};
        bitop = (grp == `GRP_CLRB) || (grp == `GRP_SETB);
        rd_w  = op inside {`OP_WLD_DIR, `OP_WLD_IX, `OP_WLD_EXT,
                           `OP_WLD_AIND, `OP_WLD_EP};
        rd_b  = bitop || (grp == `GRP_LD_RI) ||
                (op inside {`OP_LD_DIR, `OP_LD_IX, `OP_LD_EXT,
                            `OP_LD_AIND, `OP_LD_EP});
        wr_w  = op inside {`OP_WST_DIR, `OP_WST_IX, `OP_WST_EXT,
                           `OP_WST_EP, `OP_WST_TIND};
        wr_b  = (grp == `GRP_ST_RI) || (grp == `GRP_MI_RI) ||
                (op inside {`OP_ST_DIR, `OP_ST_IX, `OP_ST_EXT, `OP_ST_EP,
                            `OP_MI_DIR, `OP_MI_IX, `OP_MI_EP,
                            `OP_ST_TIND});
        if (op inside {`OP_LD_EXT, `OP_ST_EXT, `OP_WLD_EXT, `OP_WST_EXT,
                       `OP_MI_DIR, `OP_MI_IX, `OP_WLD_IMM, `OP_EP_IMM,
                       `OP_IX_IMM, `OP_SP_IMM}) begin
            len = 2'd3;
        end else if (bitop || (grp == `GRP_MI_RI) ||
                     (op inside {`OP_LD_IMM, `OP_LD_DIR, `OP_LD_IX,
                                 `OP_ST_DIR, `OP_ST_IX, `OP_WLD_DIR,
                                 `OP_WLD_IX, `OP_WST_DIR, `OP_WST_IX,
                                 `OP_MI_EP})) begin
            len = 2'd2;
        end else begin
            len = 2'd1;
        end
        // Bit-direct: address byte, bit index in opcode
        mask = 8'h01 << op[2:0];
        if (bitop || (op inside {`OP_LD_DIR, `OP_ST_DIR, `OP_MI_DIR,
                                 `OP_WLD_DIR, `OP_WST_DIR})) begin
            ea = {8'h00, r.b1};
        end else if (op inside {`OP_LD_IX, `OP_ST_IX, `OP_MI_IX,
                                `OP_WLD_IX, `OP_WST_IX}) begin
            ea = r.ix + {8'h00, r.b1};
        end else if (op inside {`OP_LD_EXT, `OP_ST_EXT,
                                `OP_WLD_EXT, `OP_WST_EXT}) begin
            ea = {r.b1, r.b2};
        end else if (op inside {`OP_LD_EP, `OP_ST_EP, `OP_MI_EP,
                                `OP_WLD_EP, `OP_WST_EP}) begin
            ea = r.ep;
        end else if (ri) begin
            // Bank registers live in data memory
            ea = `BANK_BASE + {8'h00, r.rp, op[2:0]};
        end else begin
            ea = r.acc;
        end
        if (op inside {`OP_MI_DIR, `OP_MI_IX}) begin
            bdat = r.b2;
        end else if ((op == `OP_MI_EP) || (grp == `GRP_MI_RI)) begin
            bdat = r.b1;
        end else if (op == `OP_ST_TIND) begin
            bdat = r.tmp[7:0];
        end else begin
            bdat = r.acc[7:0];
        end

        unique case (r.state)
            S_FETCH: begin
                next_r.op    = pmem_data_i;
                next_r.pc    = r.pc + 16'h0001;
                next_r.state = (len == 2'd1) ? S_ADDR : S_OPND1;
            end
            // Operands arrive in notation order, high byte first
            S_OPND1: begin
                next_r.b1    = pmem_data_i;
                next_r.pc    = r.pc + 16'h0001;
                next_r.state = (len == 2'd3) ? S_OPND2 : S_ADDR;
            end
            S_OPND2: begin
                next_r.b2    = pmem_data_i;
                next_r.pc    = r.pc + 16'h0001;
                next_r.state = S_ADDR;
            end
            S_ADDR: begin
                if (rd_b || rd_w || wr_b || wr_w) begin
                    next_r.maddr  = ea;
                    next_r.mre    = rd_b || rd_w;
                    next_r.mwe    = wr_b || wr_w;
                    if (op == `OP_WST_TIND) begin
                        next_r.mwdata = r.tmp[15:8];
                    end else if (wr_w) begin
                        next_r.mwdata = r.acc[15:8];
                    end else begin
                        next_r.mwdata = bdat;
                    end
                    next_r.state  = S_MEM1;
                end else begin
                    next_r.state = S_FETCH;
                    next_r.done  = 1'b1;
                    unique case (op)
                        `OP_LD_IMM: begin
                            next_r.tmp[7:0] = r.acc[7:0];
                            next_r.acc[7:0] = r.b1;
                            next_r.condition_flags_reg = with_nz(r.condition_flags_reg, r.b1[7],
                                                 r.b1 == 8'h00);
                        end
                        `OP_WLD_IMM: begin
                            next_r.tmp = r.acc;
                            next_r.acc = {r.b1, r.b2};
                            next_r.condition_flags_reg = with_nz(r.condition_flags_reg, r.b1[7],
                                                 {r.b1, r.b2} == 16'h0000);
                        end
                        `OP_EP_A:    next_r.ep  = r.acc;
                        `OP_A_EP:    next_r.acc = r.ep;
                        `OP_EP_IMM:  next_r.ep  = {r.b1, r.b2};
                        `OP_IX_A:    next_r.ix  = r.acc;
                        `OP_A_IX:    next_r.acc = r.ix;
                        `OP_IX_IMM:  next_r.ix  = {r.b1, r.b2};
                        `OP_SP_A:    next_r.sp  = r.acc;
                        `OP_A_SP:    next_r.acc = r.sp;
                        `OP_SP_IMM:  next_r.sp  = {r.b1, r.b2};
                        `OP_A_PC:    next_r.acc = r.pc;
                        `OP_A_PS:    next_r.acc = {r.rp, 3'b000, r.condition_flags_reg};
                        // Status word carries bank pointer and flags
                        `OP_PS_A: begin
                            next_r.rp  = r.acc[15:`PS_RP_LSB];
                            next_r.condition_flags_reg = r.acc[7:0];
                        end
                        `OP_SWAP:    next_r.acc = {r.acc[7:0], r.acc[15:8]};
                        `OP_XCH_T: begin
                            next_r.acc[7:0] = r.tmp[7:0];
                            next_r.tmp[7:0] = r.acc[7:0];
                        end
                        `OP_XCHW_T: begin
                            next_r.acc = r.tmp;
                            next_r.tmp = r.acc;
                        end
                        `OP_XCHW_EP: begin
                            next_r.acc = r.ep;
                            next_r.ep  = r.acc;
                        end
                        `OP_XCHW_IX: begin
                            next_r.acc = r.ix;
                            next_r.ix  = r.acc;
                        end
                        `OP_XCHW_SP: begin
                            next_r.acc = r.sp;
                            next_r.sp  = r.acc;
                        end
                        default:     next_r.illegal = 1'b1;
                    endcase
                end
            end
            S_MEM1: begin
                if (bitop) begin
                    next_r.mre    = 1'b0;
                    next_r.mwe    = 1'b1;
                    next_r.mwdata = (grp == `GRP_SETB) ?
                                    (dmem_rdata_i | mask) :
                                    (dmem_rdata_i & ~mask);
                    next_r.state  = S_MEM2;
                end else if (rd_w || wr_w) begin
                    // Second byte sits one address higher
                    next_r.hi     = dmem_rdata_i;
                    next_r.maddr  = r.maddr + 16'h0001;
                    next_r.mwdata = (op == `OP_WST_TIND) ? r.tmp[7:0] :
                                                          r.acc[7:0];
                    next_r.state  = S_MEM2;
                end else begin
                    if (rd_b) begin
                        // Only the low temp byte follows
                        next_r.tmp[7:0] = r.acc[7:0];
                        next_r.acc[7:0] = dmem_rdata_i;
                        // Byte loads touch N and Z only
                        next_r.condition_flags_reg = with_nz(r.condition_flags_reg, dmem_rdata_i[7],
                                             dmem_rdata_i == 8'h00);
                    end
                    next_r.mre   = 1'b0;
                    next_r.mwe   = 1'b0;
                    next_r.done  = 1'b1;
                    next_r.state = S_FETCH;
                end
            end
            S_MEM2: begin
                if (rd_w) begin
                    next_r.tmp = r.acc;
                    next_r.acc = {r.hi, dmem_rdata_i};
                    if (op != `OP_WLD_EXT) begin
                        next_r.condition_flags_reg = with_nz(r.condition_flags_reg, r.hi[7],
                                             {r.hi, dmem_rdata_i} ==
                                             16'h0000);
                    end
                end
                next_r.mre   = 1'b0;
                next_r.mwe   = 1'b0;
                next_r.done  = 1'b1;
                next_r.state = S_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            r    <= '0;
            r.pc <= `PC_RESET;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // Register views
    assign pmem_addr_o           = r.pc;
    assign pmem_rd_o             = r.state inside {S_FETCH, S_OPND1, S_OPND2};
    assign dmem_addr_o           = r.maddr;
    assign dmem_wdata_o          = r.mwdata;
    assign dmem_we_o             = r.mwe;
    assign dmem_re_o             = r.mre;
    assign instr_done_o          = r.done;
    assign illegal_op_o          = r.illegal;
    assign acc_o                 = r.acc;
    assign temp_o                = r.tmp;
    assign index_pointer_o       = r.ix;
    assign extra_pointer_o       = r.ep;
    assign stack_ptr_o           = r.sp;
    assign program_status_word_o = {r.rp, 3'b000, r.condition_flags_reg};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    word_store_order_a: assert property (
        (r.state == S_MEM1 && r.mwe && !bitop &&
         r.op inside {`OP_WST_DIR, `OP_WST_IX, `OP_WST_EXT, `OP_WST_EP})
        |-> (r.mwdata == r.acc[15:8]) ##1
            (r.mwe && r.mwdata == $past(r.acc[7:0]) &&
             r.maddr == $past(r.maddr) + 16'h0001))
        else $error("word store bytes out of order");

    word_load_order_a: assert property (
        (r.state == S_MEM2 && rd_w)
        |=> (r.acc == {$past(r.hi), $past(dmem_rdata_i)} &&
             r.tmp == $past(r.acc) && r.done))
        else $error("word load result wrong");

    byte_load_temp_a: assert property (
        (r.state == S_MEM1 && rd_b && !bitop)
        |=> (r.tmp[15:8] == $past(r.tmp[15:8]) &&
             r.tmp[7:0] == $past(r.acc[7:0]) &&
             r.acc[15:8] == $past(r.acc[15:8])))
        else $error("byte load temp update wrong");

    // V and C move only on status load
    flags_vc_keep_a: assert property (
        $changed(r.condition_flags_reg[`CCR_V:`CCR_C])
        |-> ($past(r.op) == `OP_PS_A && $past(r.state) == S_ADDR))
        else $error("V or C flag changed unexpectedly");

    // Program counter steps per fetched byte
    pc_fetch_step_a: assert property (
        (r.state inside {S_FETCH, S_OPND1, S_OPND2})
        |=> r.pc == $past(r.pc) + 16'h0001)
        else $error("program counter did not step");

    // Every instruction completes in bounded time
    instr_bound_a: assert property (
        (r.state == S_FETCH) |-> ##[1:6] (r.done || r.illegal))
        else $error("instruction did not complete");

    bank_reg_addr_a: assert property (
        (r.state == S_ADDR && ri)
        |=> (r.maddr == `BANK_BASE + {8'h00, $past(r.rp), $past(r.op[2:0])}
             && r.state == S_MEM1))
        else $error("bank register address wrong");

    swap_halves_a: assert property (
        (r.state == S_ADDR && r.op == `OP_SWAP)
        |=> r.acc == {$past(r.acc[7:0]), $past(r.acc[15:8])})
        else $error("swap result wrong");

endmodule
`default_nettype wire

// ### rtl/tid_map.svh
// Opcode, field and address constants of the transfer instruction executor
`ifndef TID_MAP_SVH
`define TID_MAP_SVH

`define PC_RESET     16'h0000
`define BANK_BASE    16'h0100
`define CCR_N        3
`define CCR_Z        2
`define CCR_V        1
`define CCR_C        0
`define PS_RP_LSB    11

`define GRP_LD_RI    5'h01
`define GRP_ST_RI    5'h09
`define GRP_MI_RI    5'h11
`define GRP_CLRB     5'h14
`define GRP_SETB     5'h15

`define OP_LD_IMM    8'h04
`define OP_LD_DIR    8'h05
`define OP_LD_IX     8'h06
`define OP_LD_EP     8'h07
`define OP_LD_EXT    8'h60
`define OP_LD_AIND   8'h92
`define OP_ST_DIR    8'h45
`define OP_ST_IX     8'h46
`define OP_ST_EP     8'h47
`define OP_ST_EXT    8'h61
`define OP_MI_DIR    8'h85
`define OP_MI_IX     8'h86
`define OP_MI_EP     8'h87
`define OP_ST_TIND   8'h82
`define OP_WST_EXT   8'hd4
`define OP_WST_DIR   8'hd5
`define OP_WST_IX    8'hd6
`define OP_WST_EP    8'hd7
`define OP_WST_TIND  8'h83
`define OP_WLD_EXT   8'hc4
`define OP_WLD_DIR   8'hc5
`define OP_WLD_IX    8'hc6
`define OP_WLD_EP    8'hc7
`define OP_WLD_AIND  8'h93
`define OP_WLD_IMM   8'he4
`define OP_EP_A      8'he3
`define OP_A_EP      8'hf3
`define OP_EP_IMM    8'he7
`define OP_IX_A      8'he2
`define OP_A_IX      8'hf2
`define OP_SP_A      8'he1
`define OP_A_SP      8'hf1
`define OP_IX_IMM    8'he6
`define OP_SP_IMM    8'he5
`define OP_A_PS      8'h70
`define OP_PS_A      8'h71
`define OP_SWAP      8'h10
`define OP_XCH_T     8'h42
`define OP_XCHW_T    8'h43
`define OP_XCHW_EP   8'hf7
`define OP_XCHW_IX   8'hf6
`define OP_XCHW_SP   8'hf5
`define OP_A_PC      8'hf0

`endif

// ### rtl/tid_pkg.sv
// Types of the transfer instruction executor
package tid_pkg;

    typedef enum logic [2:0] {
        S_FETCH, S_OPND1, S_OPND2, S_ADDR, S_MEM1, S_MEM2
    } tid_state_e;

    typedef struct packed {
        tid_state_e  state;
        logic [15:0] pc;
        logic [15:0] acc;
        logic [15:0] tmp;
        logic [15:0] ix;
        logic [15:0] ep;
        logic [15:0] sp;
        logic [4:0]  rp;
        logic [7:0]  condition_flags_reg;
        logic [7:0]  op;
        logic [7:0]  b1;
        logic [7:0]  b2;
        logic [7:0]  hi;
        logic [15:0] maddr;
        logic [7:0]  mwdata;
        logic        mwe;
        logic        mre;
        logic        done;
        logic        illegal;
    } tid_regs_s;

endpackage

// ### verif/tid_mem_model.sv
// Program ROM and data RAM model facing the transfer instruction executor
`timescale 1ns/100ps
`default_nettype none

module tid_mem_model (
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] pmem_addr_i,
    input  wire logic        pmem_rd_i,
    output logic [7:0]       pmem_data_o,
    input  wire logic [15:0] dmem_addr_i,
    input  wire logic [7:0]  dmem_wdata_i,
    input  wire logic        dmem_we_i,
    input  wire logic        dmem_re_i,
    output logic [7:0]       dmem_rdata_o
);

    logic [7:0] rom [0:255];
    logic [7:0] ram [0:65535];
    logic [7:0] last_p = 8'h00;
    logic [7:0] last_d = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Idle buses show the inverse of the last byte, never a stale copy
    always_comb begin
        pmem_data_o  = pmem_rd_i ? rom[pmem_addr_i[7:0]] : ~last_p;
        dmem_rdata_o = dmem_re_i ? ram[dmem_addr_i] : ~last_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain always so the bench may preset memory by hierarchy
    always @(posedge clk_sys_i) begin
        if (pmem_rd_i) begin
            last_p <= pmem_data_o;
        end
        if (dmem_re_i) begin
            last_d <= dmem_rdata_o;
        end
        if (dmem_we_i) begin
            ram[dmem_addr_i] <= dmem_wdata_i;
        end
    end

endmodule

`default_nettype wire

// ### verif/transfer_instruction_decoder_test.sv
// Self-checking bench running a transfer-instruction program
`timescale 1ns/100ps
`default_nettype none

module transfer_instruction_decoder_test;

    logic        clk_sys_i;
    logic        sys_rst_i;
    logic [15:0] pmem_addr_o;
    logic        pmem_rd_o;
    logic [7:0]  pmem_data_i;
    logic [15:0] dmem_addr_o;
    logic [7:0]  dmem_wdata_o;
    logic        dmem_we_o;
    logic        dmem_re_o;
    logic [7:0]  dmem_rdata_i;
    logic        instr_done_o;
    logic        illegal_op_o;
    logic [15:0] acc_o;
    logic [15:0] temp_o;
    logic [15:0] ix_o;
    logic [15:0] ep_o;
    logic [15:0] psw_o;
    logic [15:0] sp_o;
    int          errors;
    int          n_tests;
    int          wp;
    logic        ill_seen;

    tid_core dut_u (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .pmem_addr_o(pmem_addr_o), .pmem_rd_o(pmem_rd_o),
        .pmem_data_i(pmem_data_i), .dmem_addr_o(dmem_addr_o),
        .dmem_wdata_o(dmem_wdata_o), .dmem_we_o(dmem_we_o),
        .dmem_re_o(dmem_re_o), .dmem_rdata_i(dmem_rdata_i),
        .instr_done_o(instr_done_o), .illegal_op_o(illegal_op_o),
        .acc_o(acc_o), .temp_o(temp_o), .index_pointer_o(ix_o),
        .extra_pointer_o(ep_o), .stack_ptr_o(sp_o),
        .program_status_word_o(psw_o)
    );

    tid_mem_model mem_u (
        .clk_sys_i(clk_sys_i), .pmem_addr_i(pmem_addr_o),
        .pmem_rd_i(pmem_rd_o), .pmem_data_o(pmem_data_i),
        .dmem_addr_i(dmem_addr_o), .dmem_wdata_i(dmem_wdata_o),
        .dmem_we_i(dmem_we_o), .dmem_re_i(dmem_re_o),
        .dmem_rdata_o(dmem_rdata_i)
    );

    initial clk_sys_i = 1'b0;
    always #20 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // Word in memory, high byte at the lower address
    task automatic chkm(input logic [15:0] a, input logic [15:0] exp);
        chk({mem_u.ram[a], mem_u.ram[a + 16'h0001]}, exp);
    endtask

    task automatic poke(input logic [15:0] a, input logic [15:0] w);
        mem_u.ram[a] = w[15:8];
        mem_u.ram[a + 16'h0001] = w[7:0];
    endtask

    // Bytes go out in assembler operand order, high byte first
    task automatic op(input int n, input logic [23:0] b);
        for (int i = 0; i < n; i++) begin
            mem_u.rom[wp] = b[23 - 8 * i -: 8];
            wp++;
        end
    endtask

    // Waits for one instruction to end, then one more cycle to settle
    task automatic step();
        int k;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_sys_i);
            #1;
            if (instr_done_o === 1'b1 || illegal_op_o === 1'b1) break;
        end
        if (k == 40) begin
            errors++;
            $display("wrong value at %0t: no completion", $time);
            final_report();
        end
        ill_seen = illegal_op_o;
        @(posedge clk_sys_i);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst_i = 1'b1;
        errors    = 0;
        n_tests   = 0;
        wp        = 0;
        ill_seen  = 1'b0;
        for (int i = 0; i < 256; i++) mem_u.rom[i] = 8'h00;
        poke(16'h0040, 16'h8000);
        poke(16'h3020, 16'h0000);
        poke(16'h4fff, 16'habcd);
        poke(16'habcd, 16'h5678);
        poke(16'h6000, 16'h0000);
        op(3, 24'he41234);
        op(2, 24'hd58000);
        op(2, 24'h04ff00);
        op(3, 24'hd42ffe);
        op(2, 24'hc54000);
        op(3, 24'he63000);
        op(2, 24'hd61000);
        op(2, 24'hc62000);
        op(3, 24'he74fff);
        op(1, 24'hc70000);
        op(3, 24'he75010);
        op(1, 24'hd70000);
        op(1, 24'h930000);
        op(1, 24'h830000);
        op(3, 24'hc46000);
        op(1, 24'h280000);
        for (int i = 0; i < 8; i++) begin
            op(2, {8'h04, 8'h10 + i[7:0], 8'h00});
            op(1, {8'h48 + i[7:0], 16'h0000});
        end
        op(1, 24'h0b0000);
        op(3, 24'he51234);
        op(1, 24'h100000);
        op(1, 24'h710000);
        repeat (2) @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b0;
        chk(acc_o, 16'h0000);
        chk(psw_o, 16'h0000);
        step();
        chk(acc_o, 16'h1234);
        chk({14'h0000, psw_o[3:2]}, 16'h0000);
        step();
        chkm(16'h0080, 16'h1234);
        step();
        chk(acc_o, 16'h12ff);
        chk(temp_o, 16'h0034);
        chk({14'h0000, psw_o[3:2]}, 16'h0002);
        step();
        chkm(16'h2ffe, 16'h12ff);
        step();
        chk(acc_o, 16'h8000);
        chk(temp_o, 16'h12ff);
        chk({14'h0000, psw_o[3:2]}, 16'h0002);
        step();
        chk(ix_o, 16'h3000);
        step();
        chkm(16'h3010, 16'h8000);
        step();
        chk(acc_o, 16'h0000);
        chk({14'h0000, psw_o[3:2]}, 16'h0001);
        step();
        chk(ep_o, 16'h4fff);
        step();
        chk(acc_o, 16'habcd);
        step();
        step();
        chkm(16'h5010, 16'habcd);
        step();
        chk(acc_o, 16'h5678);
        chk(temp_o, 16'habcd);
        step();
        chkm(16'h5678, 16'habcd);
        step();
        chk(acc_o, 16'h0000);
        chk({14'h0000, psw_o[3:2]}, 16'h0000);
        step();
        chk({15'h0000, ill_seen}, 16'h0001);
        chk(acc_o, 16'h0000);
        repeat (16) step();
        for (int i = 0; i < 8; i++) begin
            chk({8'h00, mem_u.ram[16'h0100 + i[15:0]]},
                {8'h00, 8'h10 + i[7:0]});
        end
        step();
        chk(acc_o, 16'h0013);
        step();
        chk(sp_o, 16'h1234);
        step();
        chk(acc_o, 16'h1300);
        step();
        chk(psw_o, 16'h1000);
        final_report();
    end

endmodule

`default_nettype wire
